// ===== design/phy_cfg_pkg.sv
// Package with register map, field layout, reset values and bus types of the PHY config bank.
package phy_cfg_pkg;
   // Register indices as printed; byte address is four times the index.
   localparam logic [7:0] mirror_config_idx = 8'h31;
   localparam logic [7:0] mac_if_control_idx = 8'h32;
   localparam logic [7:0] mac_if_control_two_idx = 8'h33;
   localparam logic [7:0] fast_ethernet_config_idx = 8'h43;
   localparam logic [7:0] rx_channel_skew_status_idx = 8'h55;
   localparam logic [7:0] soft_reset_idx = 8'h1f;
   // Field positions.
   localparam int mirror_en_pos = 0;
   localparam int mac_if_enable_pos = 7;
   localparam int rx_thr_lsb = 5;
   localparam int tx_thr_lsb = 3;
   localparam int tx_clk_shift_pos = 1;
   localparam int rx_clk_shift_pos = 0;
   localparam int async_fifo_skip_pos = 4;
   localparam int timeout_off_pos = 11;
   localparam int timeout_ms_lsb = 7;
   localparam int force_good_link_pos = 6;
   localparam int ternary_pos = 5;
   localparam int gap_pos = 4;
   localparam int decoder_skip_pos = 3;
   localparam int scrambler_off_pos = 2;
   localparam int odd_nibble_pos = 1;
   localparam int early_valid_pos = 0;
   localparam int channel_b_lsb = 4;
   localparam int soft_full_reset_pos = 15;
   // Reset values.
   localparam logic [1:0] fifo_thr_rst = 2'h2;
   localparam logic [3:0] timeout_ms_rst = 4'hf;
   localparam logic mac_if_enable_rst = 1'b1;
   localparam logic ternary_rst = 1'b1;
   // Fixed pattern of the read-only reserved bits 15:1 of the mirror register.
   localparam logic [15:0] mirror_fixed_pat = 16'h0010;
   // Descrambler timeout enforcement limit.
   localparam int long_packet_us = 1500;
   localparam int clk_mhz = 40;
   localparam int long_packet_cycles = long_packet_us * clk_mhz;
   // AXI4-Lite responses.
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   // Settings that steer the RGMII and 100BASE-TX logic.
   typedef struct packed {
      logic mirror_en;
      logic mac_if_enable;
      logic [1:0] rx_fifo_mid_threshold;
      logic [1:0] tx_fifo_mid_threshold;
      logic tx_clk_shift;
      logic rx_clk_shift;
      logic async_fifo_skip;
      logic unscramble_timeout_off;
      logic [3:0] unscramble_timeout_ms;
      logic force_good_link;
      logic enhanced_ternary_detect;
      logic enhanced_gap_detect;
      logic rx_block_decoder_skip;
      logic scrambler_off;
      logic odd_nibble_detect;
      logic early_receive_valid;
   } phy_ctrl_t;

   // Per-channel skew reported by the receive aligner.
   typedef struct packed {
      logic [3:0] channel_b_alignment;
      logic [3:0] channel_a_alignment;
   } skew_t;
endpackage : phy_cfg_pkg

// ===== design/phy_rgmii_100tx_config_regs.sv
// AXI4-Lite register bank holding the PHY mirror, RGMII and 100BASE-TX settings.
`timescale 1ns/1ps
`default_nettype none
module phy_rgmii_100tx_config_regs (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire phy_cfg_pkg::skew_t skew_in,
   input wire logic rx_packet_active,
   output phy_cfg_pkg::phy_ctrl_t ctrl,
   output logic rx_packet_abort
);
   phy_cfg_pkg::phy_ctrl_t ctrl_r;
   phy_cfg_pkg::skew_t skew_r;
   logic aw_held_r;
   logic w_held_r;
   logic [11:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic soft_rst_r;
   logic abort_r;
   logic [31:0] pkt_cnt_r;
   logic do_write;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic [15:0] wr_val;
   logic rd_hit;
   logic [15:0] rd_val;
   logic [31:0] long_limit;

   assign long_limit = phy_cfg_pkg::long_packet_cycles;

   // Address and data are caught independently; the write fires once both are held.
   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
   assign wr_idx = awaddr_r[9:2];
   assign wr_val = wdata_r[15:0];
   assign rd_idx = s_axi_araddr[9:2];

   // Write address channel; ready is offered while no address is held.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_held_r <= 1'b0;
         awaddr_r <= 12'h000;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_r <= 1'b0;
         end
      end
   end

   // Write data channel, handled like the address channel.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         w_held_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (do_write) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer SLVERR and change nothing.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= phy_cfg_pkg::resp_okay;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         case (wr_idx)
            phy_cfg_pkg::mirror_config_idx,
            phy_cfg_pkg::mac_if_control_idx,
            phy_cfg_pkg::mac_if_control_two_idx,
            phy_cfg_pkg::fast_ethernet_config_idx,
            phy_cfg_pkg::rx_channel_skew_status_idx,
            phy_cfg_pkg::soft_reset_idx: s_axi_bresp <= phy_cfg_pkg::resp_okay;
            default: s_axi_bresp <= phy_cfg_pkg::resp_slverr;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Soft full reset bit: set by a write, clears itself on the next cycle as the defaults load.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= do_write && wr_idx == phy_cfg_pkg::soft_reset_idx && wstrb_r[1]
                       && wr_val[phy_cfg_pkg::soft_full_reset_pos];
      end
   end

   // Control fields. Only the low two byte lanes matter; reserved bits hold no storage.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= '0;
         ctrl_r.mac_if_enable <= phy_cfg_pkg::mac_if_enable_rst;
         ctrl_r.rx_fifo_mid_threshold <= phy_cfg_pkg::fifo_thr_rst;
         ctrl_r.tx_fifo_mid_threshold <= phy_cfg_pkg::fifo_thr_rst;
         ctrl_r.unscramble_timeout_ms <= phy_cfg_pkg::timeout_ms_rst;
         ctrl_r.enhanced_ternary_detect <= phy_cfg_pkg::ternary_rst;
      end else if (soft_rst_r) begin
         ctrl_r <= '0;
         ctrl_r.mac_if_enable <= phy_cfg_pkg::mac_if_enable_rst;
         ctrl_r.rx_fifo_mid_threshold <= phy_cfg_pkg::fifo_thr_rst;
         ctrl_r.tx_fifo_mid_threshold <= phy_cfg_pkg::fifo_thr_rst;
         ctrl_r.unscramble_timeout_ms <= phy_cfg_pkg::timeout_ms_rst;
         ctrl_r.enhanced_ternary_detect <= phy_cfg_pkg::ternary_rst;
      end else if (do_write) begin
         case (wr_idx)
            phy_cfg_pkg::mirror_config_idx: begin
               if (wstrb_r[0]) begin
                  ctrl_r.mirror_en <= wr_val[phy_cfg_pkg::mirror_en_pos];
               end
            end
            phy_cfg_pkg::mac_if_control_idx: begin
               if (wstrb_r[0]) begin
                  ctrl_r.mac_if_enable <= wr_val[phy_cfg_pkg::mac_if_enable_pos];
                  ctrl_r.rx_fifo_mid_threshold <= wr_val[phy_cfg_pkg::rx_thr_lsb +: 2];
                  ctrl_r.tx_fifo_mid_threshold <= wr_val[phy_cfg_pkg::tx_thr_lsb +: 2];
                  ctrl_r.tx_clk_shift <= wr_val[phy_cfg_pkg::tx_clk_shift_pos];
                  ctrl_r.rx_clk_shift <= wr_val[phy_cfg_pkg::rx_clk_shift_pos];
               end
            end
            phy_cfg_pkg::mac_if_control_two_idx: begin
               if (wstrb_r[0]) begin
                  ctrl_r.async_fifo_skip <= wr_val[phy_cfg_pkg::async_fifo_skip_pos];
               end
            end
            phy_cfg_pkg::fast_ethernet_config_idx: begin
               if (wstrb_r[1]) begin
                  ctrl_r.unscramble_timeout_off <= wr_val[phy_cfg_pkg::timeout_off_pos];
                  ctrl_r.unscramble_timeout_ms[3:1] <= wr_val[10:8];
               end
               if (wstrb_r[0]) begin
                  ctrl_r.unscramble_timeout_ms[0] <= wr_val[phy_cfg_pkg::timeout_ms_lsb];
                  ctrl_r.force_good_link <= wr_val[phy_cfg_pkg::force_good_link_pos];
                  ctrl_r.enhanced_ternary_detect <= wr_val[phy_cfg_pkg::ternary_pos];
                  ctrl_r.enhanced_gap_detect <= wr_val[phy_cfg_pkg::gap_pos];
                  ctrl_r.rx_block_decoder_skip <= wr_val[phy_cfg_pkg::decoder_skip_pos];
                  ctrl_r.scrambler_off <= wr_val[phy_cfg_pkg::scrambler_off_pos];
                  ctrl_r.odd_nibble_detect <= wr_val[phy_cfg_pkg::odd_nibble_pos];
                  ctrl_r.early_receive_valid <= wr_val[phy_cfg_pkg::early_valid_pos];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Settings leave through a register stage so every output comes from a flip-flop.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= '0;
         ctrl.mac_if_enable <= phy_cfg_pkg::mac_if_enable_rst;
         ctrl.rx_fifo_mid_threshold <= phy_cfg_pkg::fifo_thr_rst;
         ctrl.tx_fifo_mid_threshold <= phy_cfg_pkg::fifo_thr_rst;
         ctrl.unscramble_timeout_ms <= phy_cfg_pkg::timeout_ms_rst;
         ctrl.enhanced_ternary_detect <= phy_cfg_pkg::ternary_rst;
      end else begin
         ctrl <= ctrl_r;
      end
   end

   // Skew status is sampled every cycle from the receive aligner.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         skew_r <= '0;
      end else begin
         skew_r <= skew_in;
      end
   end

   // Descrambler timeout: a packet running past 1.5 ms is cut off unless enforcement is off.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pkt_cnt_r <= 32'h0000_0000;
         abort_r <= 1'b0;
      end else if (!rx_packet_active) begin
         pkt_cnt_r <= 32'h0000_0000;
         abort_r <= 1'b0;
      end else begin
         if (pkt_cnt_r < long_limit) begin
            pkt_cnt_r <= pkt_cnt_r + 32'h0000_0001;
         end
         abort_r <= !ctrl_r.unscramble_timeout_off && pkt_cnt_r >= long_limit;
      end
   end
   assign rx_packet_abort = abort_r;

   // Read mux; reserved bits read zero except the fixed mirror pattern.
   always_comb begin
      rd_val = 16'h0000;
      rd_hit = 1'b1;
      case (rd_idx)
         phy_cfg_pkg::mirror_config_idx: begin
            rd_val = phy_cfg_pkg::mirror_fixed_pat;
            rd_val[phy_cfg_pkg::mirror_en_pos] = ctrl_r.mirror_en;
         end
         phy_cfg_pkg::mac_if_control_idx: begin
            rd_val[phy_cfg_pkg::mac_if_enable_pos] = ctrl_r.mac_if_enable;
            rd_val[phy_cfg_pkg::rx_thr_lsb +: 2] = ctrl_r.rx_fifo_mid_threshold;
            rd_val[phy_cfg_pkg::tx_thr_lsb +: 2] = ctrl_r.tx_fifo_mid_threshold;
            rd_val[phy_cfg_pkg::tx_clk_shift_pos] = ctrl_r.tx_clk_shift;
            rd_val[phy_cfg_pkg::rx_clk_shift_pos] = ctrl_r.rx_clk_shift;
         end
         phy_cfg_pkg::mac_if_control_two_idx: begin
            rd_val[phy_cfg_pkg::async_fifo_skip_pos] = ctrl_r.async_fifo_skip;
         end
         phy_cfg_pkg::fast_ethernet_config_idx: begin
            rd_val[phy_cfg_pkg::timeout_off_pos] = ctrl_r.unscramble_timeout_off;
            rd_val[10:7] = ctrl_r.unscramble_timeout_ms;
            rd_val[6:0] = {ctrl_r.force_good_link, ctrl_r.enhanced_ternary_detect,
                           ctrl_r.enhanced_gap_detect, ctrl_r.rx_block_decoder_skip,
                           ctrl_r.scrambler_off, ctrl_r.odd_nibble_detect,
                           ctrl_r.early_receive_valid};
         end
         phy_cfg_pkg::rx_channel_skew_status_idx: begin
            rd_val[7:0] = {skew_r.channel_b_alignment, skew_r.channel_a_alignment};
         end
         phy_cfg_pkg::soft_reset_idx: begin
            rd_val[phy_cfg_pkg::soft_full_reset_pos] = soft_rst_r;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // Read channel: one cycle from address to data, one read at a time.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= phy_cfg_pkg::resp_okay;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_val};
            s_axi_rresp <= rd_hit ? phy_cfg_pkg::resp_okay : phy_cfg_pkg::resp_slverr;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Mirror enable output follows its register bit two cycles after the write completes.
   mirror_follow_a: assert property (@(posedge mclk) disable iff (sys_rst)
      do_write && !soft_rst_r && wr_idx == phy_cfg_pkg::mirror_config_idx && wstrb_r[0]
      |=> ##1 ctrl.mirror_en == $past(wr_val[phy_cfg_pkg::mirror_en_pos], 2))
      else $error("mirror output does not follow register");
   // Soft reset brings defaults in the next cycle and clears itself.
   sequence soft_rst_s;
      soft_rst_r ##1 1'b1;
   endsequence
   soft_defaults_a: assert property (@(posedge mclk) disable iff (sys_rst)
      soft_rst_s |-> !soft_rst_r && ctrl_r.mac_if_enable
      && ctrl_r.unscramble_timeout_ms == phy_cfg_pkg::timeout_ms_rst
      && ctrl_r.enhanced_ternary_detect && !ctrl_r.mirror_en)
      else $error("soft reset did not restore defaults");
   threshold_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      do_write && !soft_rst_r && wr_idx == phy_cfg_pkg::mac_if_control_idx && wstrb_r[0]
      |=> ctrl_r.rx_fifo_mid_threshold == $past(wr_val[6:5])
      && ctrl_r.tx_fifo_mid_threshold == $past(wr_val[4:3]))
      else $error("threshold field not written");
   reserved_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
      s_axi_arvalid && s_axi_arready && rd_idx == phy_cfg_pkg::mac_if_control_idx
      |=> s_axi_rvalid && s_axi_rdata[15:8] == 8'h00 && !s_axi_rdata[2])
      else $error("reserved control bits not zero");
   mirror_pattern_a: assert property (@(posedge mclk) disable iff (sys_rst)
      s_axi_arvalid && s_axi_arready && rd_idx == phy_cfg_pkg::mirror_config_idx
      |=> s_axi_rdata[15:1] == phy_cfg_pkg::mirror_fixed_pat[15:1])
      else $error("mirror reserved pattern wrong");
   skew_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      s_axi_arvalid && s_axi_arready && rd_idx == phy_cfg_pkg::rx_channel_skew_status_idx
      |=> s_axi_rdata[7:4] == $past(skew_r.channel_b_alignment))
      else $error("channel B skew misreported");
   abort_cause_a: assert property (@(posedge mclk) disable iff (sys_rst)
      rx_packet_abort |-> $past(rx_packet_active) && !$past(ctrl_r.unscramble_timeout_off))
      else $error("packet aborted without cause");
   early_valid_a: assert property (@(posedge mclk) disable iff (sys_rst)
      do_write && !soft_rst_r && wr_idx == phy_cfg_pkg::fast_ethernet_config_idx && wstrb_r[0]
      |=> ctrl_r.early_receive_valid == $past(wr_val[0])
      && ctrl_r.scrambler_off == $past(wr_val[2]))
      else $error("100BASE-TX option not written");
endmodule : phy_rgmii_100tx_config_regs
`default_nettype wire

// ===== tb/phy_rx_side_model.sv
// Receive-side partner model that feeds skew reports and packet activity.
`timescale 1ns/1ps
`default_nettype none
module phy_rx_side_model (
   input wire logic mclk,
   input wire logic [7:0] skew_set,
   output phy_cfg_pkg::skew_t skew_in,
   output var logic rx_packet_active
);
   // The aligner reports its skew as a registered level, as real logic would.
   always_ff @(posedge mclk) begin
      skew_in <= skew_set;
   end

   initial rx_packet_active = 1'b0;

   // Holds the receive line busy for n cycles; changes only after a rising edge.
   task automatic run_packet(input int n);
      @(posedge mclk);
      rx_packet_active <= 1'b1;
      repeat (n) @(posedge mclk);
      rx_packet_active <= 1'b0;
   endtask : run_packet
endmodule : phy_rx_side_model
`default_nettype wire

// ===== tb/phy_rgmii_100tx_config_regs_bench.sv
// Self-checking bench for the PHY configuration register bank over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module phy_rgmii_100tx_config_regs_bench;
   // Byte addresses are four times the register index.
   localparam logic [11:0] a_mir = {2'h0, phy_cfg_pkg::mirror_config_idx, 2'h0};
   localparam logic [11:0] a_mac = {2'h0, phy_cfg_pkg::mac_if_control_idx, 2'h0};
   localparam logic [11:0] a_two = {2'h0, phy_cfg_pkg::mac_if_control_two_idx, 2'h0};
   localparam logic [11:0] a_cfg = {2'h0, phy_cfg_pkg::fast_ethernet_config_idx, 2'h0};
   localparam logic [11:0] a_skw = {2'h0, phy_cfg_pkg::rx_channel_skew_status_idx, 2'h0};
   localparam logic [11:0] a_rst = 12'h07c;
   localparam logic [11:0] a_bad = 12'h100;
   logic mclk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, rx_packet_active, rx_packet_abort;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, got;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic [7:0] skew_set;
   phy_cfg_pkg::skew_t skew_in;
   phy_cfg_pkg::phy_ctrl_t ctrl;
   int errors, n_checks;
   logic [11:0] adr [4] = '{a_mir, a_mac, a_two, a_cfg};
   logic [31:0] ones [4] = '{32'h11, 32'hfb, 32'h10, 32'hfff};
   logic [31:0] zero [4] = '{32'h10, 32'h0, 32'h0, 32'h0};
   logic [31:0] dflt [4] = '{32'h10, 32'hd0, 32'h0, 32'h7a0};

   phy_rgmii_100tx_config_regs dut (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .skew_in(skew_in), .rx_packet_active(rx_packet_active),
      .ctrl(ctrl), .rx_packet_abort(rx_packet_abort));

   phy_rx_side_model model (.mclk(mclk), .skew_set(skew_set), .skew_in(skew_in),
      .rx_packet_active(rx_packet_active));

   // The clock toggles every half period of 25 ns.
   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   // Settings the bank should present, built from register images.
   function automatic phy_cfg_pkg::phy_ctrl_t exp_ctrl(input logic [15:0] m, c, t, f);
      return {m[0], c[7], c[6:5], c[4:3], c[1], c[0], t[4], f[11], f[10:7], f[6:0]};
   endfunction : exp_ctrl

   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk_word

   // Sampled at the falling edge so the launching edge's updates have landed.
   task automatic chk_ctrl(input phy_cfg_pkg::phy_ctrl_t e);
      @(negedge mclk);
      n_checks++;
      if (ctrl !== e) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, ctrl, e);
      end
   endtask : chk_ctrl

   // Ready levels seen at the falling edge are those sampled at the next rising edge.
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      logic aw_t, w_t, b_t;
      int n;
      n = 0;
      @(posedge mclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge mclk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         b_t = bvalid;
         r = bresp;
         n++;
         @(posedge mclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         if (b_t) bready <= 1'b0;
      end while (b_t !== 1'b1 && n < 200);
      if (b_t !== 1'b1) chk_word(32'h0, 32'h1);
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_t, r_t;
      int n;
      n = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge mclk);
         ar_t = arvalid && arready;
         r_t = rvalid;
         d = rdata;
         r = rresp;
         n++;
         @(posedge mclk);
         if (ar_t) arvalid <= 1'b0;
         if (r_t) rready <= 1'b0;
      end while (r_t !== 1'b1 && n < 200);
      if (r_t !== 1'b1) chk_word(32'h0, 32'h1);
   endtask : axi_rd

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      axi_rd(a, got, rsp);
      chk_word({30'h0, rsp}, {30'h0, phy_cfg_pkg::resp_okay});
      chk_word(got, e);
   endtask : rd_chk

   task automatic summarize;
      if (errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   // A hang is cut short well after the long-packet test should be over.
   initial begin
      repeat (75000) @(posedge mclk);
      errors++;
      summarize();
   end

   // Main sequence; bus signals start idle and reset is held for ten cycles.
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      errors = 0;
      n_checks = 0;
      skew_set = 8'h5a;
      sys_rst = 1'b1;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      chk_ctrl(exp_ctrl(16'h10, 16'hd0, 16'h0, 16'h7a0));
      rd_chk(a_mir, 32'h10);
      rd_chk(a_mac, 32'hd0);
      rd_chk(a_two, 32'h0);
      rd_chk(a_cfg, 32'h7a0);
      rd_chk(a_skw, 32'h5a);
      // All ones, then all zeros: reserved bits must not stick.
      for (int i = 0; i < 4; i++) axi_wr(adr[i], 32'hffffffff, 4'hf, rsp);
      for (int i = 0; i < 4; i++) rd_chk(adr[i], ones[i]);
      chk_ctrl(exp_ctrl(16'h11, 16'hfb, 16'h10, 16'hfff));
      for (int i = 0; i < 4; i++) axi_wr(adr[i], 32'h0, 4'hf, rsp);
      for (int i = 0; i < 4; i++) rd_chk(adr[i], zero[i]);
      chk_ctrl(exp_ctrl(16'h10, 16'h0, 16'h0, 16'h0));
      // One bit at a time, so a swapped field shows up.
      for (int i = 0; i < 12; i++) begin
         axi_wr(a_mac, 32'h1 << i, 4'hf, rsp);
         axi_wr(a_cfg, 32'h1 << i, 4'hf, rsp);
         rd_chk(a_mac, (32'h1 << i) & 32'hfb);
         chk_ctrl(exp_ctrl(16'h10, 16'h1 << i & 16'hfb, 16'h0, 16'h1 << i));
      end
      // Byte lanes: lane one alone, then lane zero alone.
      axi_wr(a_cfg, 32'h08ff, 4'h2, rsp);
      rd_chk(a_cfg, 32'h0800);
      axi_wr(a_cfg, 32'h00ff, 4'h1, rsp);
      rd_chk(a_cfg, 32'h08ff);
      // Status is read-only and follows the aligner; the new skew needs two stages to land.
      skew_set <= 8'hc3;
      axi_wr(a_skw, 32'hffff, 4'hf, rsp);
      rd_chk(a_skw, 32'hc3);
      axi_wr(a_bad, 32'hffff, 4'hf, rsp);
      chk_word({30'h0, rsp}, {30'h0, phy_cfg_pkg::resp_slverr});
      axi_rd(a_bad, got, rsp);
      chk_word({30'h0, rsp}, {30'h0, phy_cfg_pkg::resp_slverr});
      // Soft full reset brings every field back and clears itself, mirror and bypass too.
      axi_wr(a_mir, 32'h1, 4'h1, rsp);
      axi_wr(a_two, 32'h10, 4'h1, rsp);
      axi_wr(a_rst, 32'h8000, 4'hf, rsp);
      rd_chk(a_rst, 32'h0);
      for (int i = 0; i < 4; i++) rd_chk(adr[i], dflt[i]);
      chk_ctrl(exp_ctrl(16'h10, 16'hd0, 16'h0, 16'h7a0));
      // Long packet with enforcement on: abort only past the limit.
      fork
         model.run_packet(phy_cfg_pkg::long_packet_cycles + 20);
         begin
            repeat (phy_cfg_pkg::long_packet_cycles - 20) @(posedge mclk);
            @(negedge mclk);
            chk_word({31'h0, rx_packet_abort}, 32'h0);
            repeat (32) @(posedge mclk);
            @(negedge mclk);
            chk_word({31'h0, rx_packet_abort}, 32'h1);
         end
      join
      repeat (3) @(negedge mclk);
      chk_word({31'h0, rx_packet_abort}, 32'h0);
      summarize();
   end
endmodule : phy_rgmii_100tx_config_regs_bench
`default_nettype wire
